// file: common/ckoc_pkg.sv
package ckoc_pkg;

  // Output counts
  localparam int          NUM_PAIRS          = 6;

  // Bus address chosen by the address strap
  localparam logic [6:0]  BUS_ADDR_STRAP_LOW  = 7'h68;
  localparam logic [6:0]  BUS_ADDR_STRAP_HIGH = 7'h6A;

  // Register byte offsets
  localparam logic [7:0]  REG_PAIR_ENABLE    = 8'h00;
  localparam logic [7:0]  REG_REF_CTRL       = 8'h04;
  localparam logic [7:0]  REG_PARK_CTRL      = 8'h08;
  localparam logic [7:0]  REG_SPREAD_CTRL    = 8'h0C;
  localparam logic [7:0]  REG_STATUS         = 8'h10;

  // Field positions
  localparam int          REF_ENABLE_BIT     = 4;
  localparam int          REF_RUN_PD_BIT     = 5;
  localparam int          SPREAD_OVR_BIT     = 2;
  localparam int          ST_STRAPPED_BIT    = 0;
  localparam int          ST_LOCK_BIT        = 1;
  localparam int          ST_PWRDN_BIT       = 2;
  localparam int          ST_SPREAD_LSB      = 3;
  localparam int          ST_ADDR_LSB        = 5;
  localparam int          ST_RUN_LSB         = 12;
  localparam int          ST_REF_RUN_BIT     = 18;

  // Reset values
  localparam logic [5:0]  PAIR_ENABLE_RST    = 6'h3F;
  localparam logic        REF_ENABLE_RST     = 1'b1;
  localparam logic        REF_RUN_PD_RST     = 1'b0;
  localparam logic [1:0]  PARK_RST           = 2'h0;
  localparam logic        SPREAD_OVR_RST     = 1'b0;
  localparam logic [1:0]  SPREAD_VAL_RST     = 2'h0;

  // Spread selections driven to the synthesis loop
  localparam logic [1:0]  SPREAD_OFF         = 2'h0;
  localparam logic [1:0]  SPREAD_QUARTER     = 2'h1;
  localparam logic [1:0]  SPREAD_HALF        = 2'h2;

  // Tri-level strap as decoded by the pad: low, mid, high
  localparam logic [1:0]  TRI_LOW            = 2'h0;
  localparam logic [1:0]  TRI_MID            = 2'h1;
  localparam logic [1:0]  TRI_HIGH           = 2'h2;

  // Power sequencing states
  typedef enum logic [2:0] {
    PS_WAIT = 3'b001,
    PS_RUN  = 3'b010,
    PS_DOWN = 3'b100
  } ckoc_pwr_state_t;

endpackage : ckoc_pkg

// file: common/ckoc_strap_if.sv
`timescale 1ns/1ps
`default_nettype none

// Strap results handed from the latch to the controller
interface ckoc_strap_if;
  logic       strapped;
  logic [6:0] bus_addr;
  logic [1:0] spread_strap;

  modport prod (output strapped, output bus_addr, output spread_strap);
  modport cons (input strapped, input bus_addr, input spread_strap);
endinterface : ckoc_strap_if

`default_nettype wire

// file: verilog/ckoc_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none

module ckoc_strap_latch (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pg_i,
  input  wire logic       addr_strap_i,
  input  wire logic [1:0] spread_strap_i,
  ckoc_strap_if.prod      strap
);

  logic       strapped_r;
  logic [6:0] addr_r;
  logic [1:0] spread_r;

  // Capture both straps once, on the first power-good high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strapped_r <= 1'b0;
      addr_r     <= ckoc_pkg::BUS_ADDR_STRAP_LOW;
      spread_r   <= ckoc_pkg::SPREAD_OFF;
    end else if (pg_i && !strapped_r) begin
      strapped_r <= 1'b1;
      addr_r     <= addr_strap_i ? ckoc_pkg::BUS_ADDR_STRAP_HIGH
                                 : ckoc_pkg::BUS_ADDR_STRAP_LOW;
      if (spread_strap_i == ckoc_pkg::TRI_HIGH) begin
        spread_r <= ckoc_pkg::SPREAD_HALF;
      end else if (spread_strap_i == ckoc_pkg::TRI_MID) begin
        spread_r <= ckoc_pkg::SPREAD_QUARTER;
      end else begin
        spread_r <= ckoc_pkg::SPREAD_OFF;
      end
    end
  end

  assign strap.strapped     = strapped_r;
  assign strap.bus_addr     = addr_r;
  assign strap.spread_strap = spread_r;

endmodule : ckoc_strap_latch

`default_nettype wire

// file: verilog/ckoc_pair_gate.sv
`timescale 1ns/1ps
`default_nettype none

module ckoc_pair_gate (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       synth_clk_i,
  input  wire logic       want_run_i,
  input  wire logic       force_off_i,
  input  wire logic [1:0] park_i,
  output var  logic       true_o,
  output var  logic       comp_o,
  output var  logic       running_o
);

  logic run_r;

  // Gate follows the request only while the clock is low, so no runt pulse; force-off closes it at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
    end else if (force_off_i) begin
      run_r <= 1'b0;
    end else if (!synth_clk_i) begin
      run_r <= want_run_i;
    end
  end

  // Legs follow the clock or sit in the parked levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      true_o <= 1'b0;
      comp_o <= 1'b0;
    end else if (run_r) begin
      true_o <= synth_clk_i;
      comp_o <= ~synth_clk_i;
    end else begin
      true_o <= park_i[0];
      comp_o <= park_i[1];
    end
  end

  assign running_o = run_r;

endmodule : ckoc_pair_gate

`default_nettype wire

// file: verilog/ckoc_top.sv
`timescale 1ns/1ps
`default_nettype none

module ckoc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Board control pins
  input  wire logic        power_good_powerdown_n_i,
  input  wire logic [5:0]  pair_output_enable_n_i,
  input  wire logic [1:0]  spread_strap_i,
  // Address strap pin, later the reference copy
  input  wire logic        bus_address_strap_i,
  output var  logic        bus_address_strap_o,
  output var  logic        bus_address_strap_oe_o,
  // Clock sources and loop status
  input  wire logic        synth_clk_i,
  input  wire logic        ref_clk_i,
  input  wire logic        pll_lock_i,
  // Differential pairs and loop controls
  output logic [5:0]       diff_clock_pair_true_o,
  output logic [5:0]       diff_clock_pair_comp_o,
  output var  logic [1:0]  spread_sel_o,
  output logic [6:0]       bus_addr_o
);

  ckoc_strap_if strap ();

  ckoc_pkg::ckoc_pwr_state_t pwr_r;
  ckoc_pkg::ckoc_pwr_state_t pwr_nxt;

  logic [5:0]  pair_en_r;
  logic        ref_en_r;
  logic        ref_run_pd_r;
  logic [1:0]  parked_output_state_field_r;
  logic        spread_ovr_r;
  logic [1:0]  spread_val_r;
  logic        ack_r;
  logic        ref_run_r;
  logic        ref_drive_r;
  logic [1:0]  spread_eff;
  logic [5:0]  pair_want;
  logic [5:0]  pair_running;
  logic        wr_stb;
  logic        pg;
  logic [31:0] rd_data;

  assign pg = power_good_powerdown_n_i;

  // Strap capture on first power-good
  ckoc_strap_latch u_strap (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .pg_i           (pg),
    .addr_strap_i   (bus_address_strap_i),
    .spread_strap_i (spread_strap_i),
    .strap          (strap.prod)
  );

  // Power sequencing next state
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ckoc_pkg::PS_WAIT: begin
        if (pg) begin
          pwr_nxt = ckoc_pkg::PS_RUN;
        end
      end
      ckoc_pkg::PS_RUN: begin
        if (!pg) begin
          pwr_nxt = ckoc_pkg::PS_DOWN;
        end
      end
      ckoc_pkg::PS_DOWN: begin
        if (pg) begin
          pwr_nxt = ckoc_pkg::PS_RUN;
        end
      end
      default: begin
        pwr_nxt = ckoc_pkg::PS_WAIT;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r <= ckoc_pkg::PS_WAIT;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Bus write strobe, taken on the acknowledging edge
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

  // Wishbone acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  assign wb_ack_o = ack_r;

  // Pair enable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_en_r <= ckoc_pkg::PAIR_ENABLE_RST;
    end else if (wr_stb && wb_adr_i == ckoc_pkg::REG_PAIR_ENABLE) begin
      pair_en_r <= wb_dat_i[5:0];
    end
  end

  // Reference enable and run-in-powerdown bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_en_r     <= ckoc_pkg::REF_ENABLE_RST;
      ref_run_pd_r <= ckoc_pkg::REF_RUN_PD_RST;
    end else if (wr_stb && wb_adr_i == ckoc_pkg::REG_REF_CTRL) begin
      ref_en_r     <= wb_dat_i[ckoc_pkg::REF_ENABLE_BIT];
      ref_run_pd_r <= wb_dat_i[ckoc_pkg::REF_RUN_PD_BIT];
    end
  end

  // Parked leg levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parked_output_state_field_r <= ckoc_pkg::PARK_RST;
    end else if (wr_stb && wb_adr_i == ckoc_pkg::REG_PARK_CTRL) begin
      parked_output_state_field_r <= wb_dat_i[1:0];
    end
  end

  // Spread override
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spread_ovr_r <= ckoc_pkg::SPREAD_OVR_RST;
      spread_val_r <= ckoc_pkg::SPREAD_VAL_RST;
    end else if (wr_stb && wb_adr_i == ckoc_pkg::REG_SPREAD_CTRL) begin
      spread_ovr_r <= wb_dat_i[ckoc_pkg::SPREAD_OVR_BIT];
      spread_val_r <= wb_dat_i[1:0];
    end
  end

  // Effective spread: bus override or latched strap
  always_comb begin
    if (spread_ovr_r) begin
      spread_eff = (spread_val_r == ckoc_pkg::SPREAD_HALF)
                   ? ckoc_pkg::SPREAD_HALF
                   : spread_val_r;
    end else begin
      spread_eff = strap.spread_strap;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spread_sel_o <= ckoc_pkg::SPREAD_OFF;
    end else if (spread_eff == 2'h3) begin
      spread_sel_o <= ckoc_pkg::SPREAD_OFF;
    end else begin
      spread_sel_o <= spread_eff;
    end
  end

  // Per-pair run request from power-good, bus bit and pin
  always_comb begin
    for (int i = 0; i < ckoc_pkg::NUM_PAIRS; i++) begin
      pair_want[i] = (pwr_r == ckoc_pkg::PS_RUN)
                     && pair_en_r[i]
                     && !pair_output_enable_n_i[i];
    end
  end

  // One gate per differential pair
  for (genvar g = 0; g < ckoc_pkg::NUM_PAIRS; g++) begin : g_pair
    ckoc_pair_gate u_gate (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .synth_clk_i (synth_clk_i),
      .want_run_i  (pair_want[g]),
      .force_off_i (!pll_lock_i),
      .park_i      (parked_output_state_field_r),
      .true_o      (diff_clock_pair_true_o[g]),
      .comp_o      (diff_clock_pair_comp_o[g]),
      .running_o   (pair_running[g])
    );
  end

  // Reference copy gating, switched while the reference is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_run_r <= 1'b0;
    end else if (!ref_clk_i) begin
      if (pwr_r == ckoc_pkg::PS_RUN) begin
        ref_run_r <= ref_en_r;
      end else if (pwr_r == ckoc_pkg::PS_DOWN) begin
        ref_run_r <= ref_run_pd_r;
      end else begin
        ref_run_r <= 1'b0;
      end
    end
  end

  // Pin is an input until the straps are taken, then drives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_drive_r <= 1'b0;
    end else begin
      ref_drive_r <= strap.strapped;
    end
  end

  assign bus_address_strap_oe_o = ref_drive_r;

  // Reference copy data, low when disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_address_strap_o <= 1'b0;
    end else begin
      bus_address_strap_o <= ref_run_r && ref_clk_i;
    end
  end

  assign bus_addr_o = strap.bus_addr;

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == ckoc_pkg::REG_PAIR_ENABLE) begin
      rd_data[5:0] = pair_en_r;
    end else if (wb_adr_i == ckoc_pkg::REG_REF_CTRL) begin
      rd_data[ckoc_pkg::REF_ENABLE_BIT] = ref_en_r;
      rd_data[ckoc_pkg::REF_RUN_PD_BIT] = ref_run_pd_r;
    end else if (wb_adr_i == ckoc_pkg::REG_PARK_CTRL) begin
      rd_data[1:0] = parked_output_state_field_r;
    end else if (wb_adr_i == ckoc_pkg::REG_SPREAD_CTRL) begin
      rd_data[ckoc_pkg::SPREAD_OVR_BIT] = spread_ovr_r;
      rd_data[1:0] = spread_val_r;
    end else if (wb_adr_i == ckoc_pkg::REG_STATUS) begin
      rd_data[ckoc_pkg::ST_STRAPPED_BIT] = strap.strapped;
      rd_data[ckoc_pkg::ST_LOCK_BIT] = pll_lock_i;
      rd_data[ckoc_pkg::ST_PWRDN_BIT] = (pwr_r == ckoc_pkg::PS_DOWN);
      rd_data[ckoc_pkg::ST_SPREAD_LSB +: 2] = spread_sel_o;
      rd_data[ckoc_pkg::ST_ADDR_LSB +: 7] = strap.bus_addr;
      rd_data[ckoc_pkg::ST_RUN_LSB +: 6] = pair_running;
      rd_data[ckoc_pkg::ST_REF_RUN_BIT] = ref_run_r;
    end
  end

  // Read data register, loaded with the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      wb_dat_o <= rd_data;
    end
  end

endmodule : ckoc_top

`default_nettype wire

// file: test/ckoc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module ckoc_board_model (
  input  wire logic unlock_i,
  input  wire logic clk_i,
  input  wire logic rst_i,
  output var  logic synth_clk_o,
  output wire logic ref_clk_o,
  output var  logic pll_lock_o
);
  logic [4:0] cnt_r;

  // Loop clock toggles each cycle, slower reference clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r       <= 5'h00;
      synth_clk_o <= 1'b0;
    end else begin
      cnt_r       <= cnt_r + 5'h01;
      synth_clk_o <= !synth_clk_o;
    end
  end
  assign ref_clk_o = cnt_r[2];

  // Lock comes late after reset and drops on request
  always_ff @(posedge clk_i) begin
    if (rst_i || unlock_i) begin
      pll_lock_o <= 1'b0;
    end else if (cnt_r == 5'h1F) begin
      pll_lock_o <= 1'b1;
    end
  end
endmodule : ckoc_board_model

`default_nettype wire

// file: test/ckoc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module ckoc_top_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       power_good_powerdown_n_i,
  input wire logic [5:0] pair_output_enable_n_i,
  input wire logic [1:0] spread_strap_i,
  input wire logic       bus_address_strap_i,
  input wire logic       bus_address_strap_oe_o,
  input wire logic       bus_address_strap_o,
  input wire logic       ref_clk_i,
  input wire logic       synth_clk_i,
  input wire logic       pll_lock_i,
  input wire logic [5:0] diff_clock_pair_true_o,
  input wire logic [5:0] diff_clock_pair_comp_o,
  input wire logic [1:0] spread_sel_o,
  input wire logic [6:0] bus_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic       seen_r;
  logic [6:0] addr_r;
  logic [1:0] spr_r;
  wire logic  first_w = !seen_r && power_good_powerdown_n_i;

  // First power-good and the straps it found
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
    end else if (first_w) begin
      seen_r <= 1'b1;
      addr_r <= bus_address_strap_i ? 7'h6A : 7'h68;
      spr_r  <= (spread_strap_i == 2'h3) ? 2'h0 : spread_strap_i;
    end
  end

  property p_addr_latch;
    first_w |-> ##3 bus_addr_o == addr_r;
  endproperty
  a_addr_latch: assert property (p_addr_latch)
    else $error("bus address not from strap");
  property p_spread_latch;
    first_w |-> ##3 spread_sel_o == spr_r;
  endproperty
  a_spread_latch: assert property (p_spread_latch)
    else $error("spread not from strap");
  property p_park_hold;
    (!power_good_powerdown_n_i)[*6] |->
      $stable(diff_clock_pair_true_o) && $stable(diff_clock_pair_comp_o);
  endproperty
  a_park_hold: assert property (p_park_hold)
    else $error("legs move in power down");
  property p_ref_hiz;
    !seen_r |-> !bus_address_strap_oe_o;
  endproperty
  a_ref_hiz: assert property (p_ref_hiz)
    else $error("strap pin driven too early");
  property p_ref_drive;
    seen_r && $past(seen_r) |-> bus_address_strap_oe_o;
  endproperty
  a_ref_drive: assert property (p_ref_drive)
    else $error("strap pin not driven");
  property p_ref_copy;
    bus_address_strap_o |-> $past(ref_clk_i);
  endproperty
  a_ref_copy: assert property (p_ref_copy)
    else $error("strap pin high without reference high");
  property p_lock_block;
    (!pll_lock_i)[*4] |->
      $stable(diff_clock_pair_true_o) && $stable(diff_clock_pair_comp_o);
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("legs move without lock");
  property p_pin_off;
    pair_output_enable_n_i[0][*5] |-> $stable(diff_clock_pair_true_o[0]);
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pair 0 runs with pin high");
  property p_boundary;
    $changed(diff_clock_pair_true_o[0]) && $past(pll_lock_i) |->
      diff_clock_pair_true_o[0] == $past(synth_clk_i);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("pair 0 edge off the loop clock");

  c_first: cover property (first_w);
  c_run: cover property ($rose(diff_clock_pair_true_o[0]));
  c_down: cover property (seen_r && $fell(power_good_powerdown_n_i));
endmodule : ckoc_top_assertions

bind ckoc_top ckoc_top_assertions u_ckoc_chk (
  .clk_i, .rst_i, .power_good_powerdown_n_i, .pair_output_enable_n_i,
  .spread_strap_i, .bus_address_strap_i, .bus_address_strap_oe_o,
  .bus_address_strap_o, .ref_clk_i,
  .synth_clk_i, .pll_lock_i, .diff_clock_pair_true_o,
  .diff_clock_pair_comp_o, .spread_sel_o, .bus_addr_o
);

`default_nettype wire

// file: test/ckoc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ckoc_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        pg = 1'b0;
  logic [5:0]  pin_n = 6'h00;
  logic [1:0]  spr = 2'h0;
  logic        astrap = 1'b0;
  logic        unlock = 1'b0;
  logic        prev_ref;
  logic [31:0] lfsr = 32'h0000_e651;
  logic [31:0] rdat, exp_q[$], msk_q[$];
  logic        ack, synth, refc, lock, a_o, a_oe;
  logic [5:0]  tru, cmp;
  logic [1:0]  spr_o;
  logic [6:0]  addr_o;
  int          miscompares = 0;
  int          comparisons = 0;

  always #5 clk_i = !clk_i;

  ckoc_board_model u_board (.clk_i(clk_i), .rst_i(rst_i), .unlock_i(unlock),
    .synth_clk_o(synth), .ref_clk_o(refc), .pll_lock_o(lock));

  ckoc_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .power_good_powerdown_n_i(pg),
    .pair_output_enable_n_i(pin_n), .spread_strap_i(spr),
    .bus_address_strap_i(a_oe ? a_o : astrap), .bus_address_strap_o(a_o),
    .bus_address_strap_oe_o(a_oe), .synth_clk_i(synth), .ref_clk_i(refc),
    .pll_lock_i(lock), .diff_clock_pair_true_o(tru),
    .diff_clock_pair_comp_o(cmp), .spread_sel_o(spr_o), .bus_addr_o(addr_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w

  // One classic cycle; reads leave a note for the monitor
  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, m = 32'h0, e = 32'h0);
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= wr;
    adr  <= a;
    wdat <= d;
    if (!wr) begin
      msk_q.push_back(m);
      exp_q.push_back(e & m);
    end
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask : bus

  task automatic drive(input logic p, input logic [5:0] n);
    @(posedge clk_i);
    pg    <= p;
    pin_n <= n;
  endtask : drive

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Oldest note against each read answer
  always @(posedge clk_i) begin
    if (ack && cyc && !we) begin
      chk("status", rdat & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // Cut a hung run short
  initial begin
    #200_000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    // Each strap setting after a fresh reset
    for (int s = 0; s < 3; s++) begin
      w(8);
      rst_i <= 1'b0;
      w(3);
      chk("strap_oe", {31'h0, a_oe}, 32'h0);
      drive(1'b1, 6'h00);
      w(40);
      chk("bus_addr", {25'h0, addr_o}, s[0] ? 32'h6A : 32'h68);
      chk("strap_oe", {31'h0, a_oe}, 32'h1);
      bus(8'h10, 1'b0, 32'h0, 32'h0007_FFFF, {13'h0, 1'b1, 6'h3F,
          s[0] ? 7'h6A : 7'h68, s[1:0], 3'b011});
      @(posedge clk_i);
      rst_i  <= (s < 2);
      pg     <= 1'b0;
      spr    <= 2'(s + 1);
      astrap <= !astrap;
    end
    // Random bus enable bits against random pin levels
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      bus(8'h00, 1'b1, {26'h0, lfsr[5:0]});
      drive(1'b1, lfsr[13:8]);
      w(6);
      bus(8'h10, 1'b0, 32'h0, 32'h0007_F004,
          {13'h0, 1'b1, lfsr[5:0] & ~lfsr[13:8], 12'h0});
    end
    bus(8'h24, 1'b1, 32'hFFFF_FFFF);
    bus(8'h24, 1'b0, 32'h0, 32'hFFFF_FFFF, 32'h0);
    // Reference copy follows the reference one edge late
    repeat (8) begin
      @(posedge clk_i);
      prev_ref = refc;
      @(posedge clk_i);
      chk("ref_copy", {31'h0, a_o}, {31'h0, prev_ref});
    end
    // Bus override of the spread amount
    for (int v = 0; v < 3; v++) begin
      bus(8'h0C, 1'b1, 32'h4 | 32'(v));
      bus(8'h10, 1'b0, 32'h0, 32'h0000_0018, 32'(v) << 3);
      chk("spread_sel", {30'h0, spr_o}, 32'(v));
    end
    // Reference off by bus bit, then power down
    bus(8'h00, 1'b1, 32'h3F);
    drive(1'b1, 6'h00);
    bus(8'h04, 1'b1, 32'h0);
    w(8);
    bus(8'h10, 1'b0, 32'h0, 32'h0007_F004, 32'h0003_F000);
    chk("ref_copy", {31'h0, a_o}, 32'h0);
    bus(8'h04, 1'b1, 32'h10);
    bus(8'h08, 1'b1, 32'h2);
    drive(1'b0, 6'h00);
    w(8);
    bus(8'h10, 1'b0, 32'h0, 32'h0007_F004, 32'h0000_0004);
    chk("ref_copy", {31'h0, a_o}, 32'h0);
    chk("legs", {20'h0, tru, cmp}, 32'h0000_003F);
    bus(8'h04, 1'b1, 32'h30);
    w(8);
    bus(8'h10, 1'b0, 32'h0, 32'h0004_0000, 32'h0004_0000);
    drive(1'b1, 6'h00);
    bus(8'h08, 1'b1, 32'h0);
    w(8);
    bus(8'h10, 1'b0, 32'h0, 32'h0003_F004, 32'h0003_F000);
    // Loss of lock blocks every pair until relock
    unlock <= 1'b1;
    w(6);
    chk("legs", {20'h0, tru, cmp}, 32'h0);
    bus(8'h10, 1'b0, 32'h0, 32'h0003_F002, 32'h0);
    unlock <= 1'b0;
    w(40);
    bus(8'h10, 1'b0, 32'h0, 32'h0003_F002, 32'h0003_F002);
    tally_and_finish();
  end
endmodule : ckoc_top_tb

`default_nettype wire
